/* File: core/xmem_consts.svh */
/*
 * Offsets, field positions, keys and timing counts of the data memory
 * and external bus block. Assumes inclusion by bare name from core/.
 */
`ifndef XMEM_CONSTS_SVH
`define XMEM_CONSTS_SVH

// ****************************************
// Special function register offsets
// ****************************************
`define OFS_AUX_RAM_HIGH_PAGE   8'hA1
`define OFS_CHIP_CONTROL        8'hBF
`define OFS_CHIP_CONTROL_UNLOCK 8'hF6

// ****************************************
// Fields and keys
// ****************************************
`define CC_AUX_EN_BIT           4
`define UNLOCK_KEY_FIRST        8'h87
`define UNLOCK_KEY_SECOND       8'h59
`define SFR_RESET_VALUE         8'h00
`define SCRATCH_DIRECT_TOP      8'h7F
`define AUX_RAM_TOP             16'h03FF

// ****************************************
// Timing counts in clk_sys cycles, reset hold in machine cycles
// ****************************************
`define ALE_DIVIDE              6
`define OSC_PER_MACHINE_CYCLE   12
`define RESET_MACHINE_CYCLES    2

`endif

/* File: core/xmem_pkg.sv */
/*
 * Types shared by the data memory and external bus block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package xmem_pkg;

    typedef enum logic [2:0] {
        OP_FETCH,       // Program fetch
        OP_DIRECT,      // Scratchpad, direct address
        OP_INDIRECT,    // Scratchpad, through pointer_reg_zero or pointer_reg_one
        OP_XPTR8,       // external_data_move through an 8-bit pointer
        OP_XDPTR        // external_data_move through data_pointer_16bit
    } mem_op_t;

    typedef struct packed {
        logic        valid;
        mem_op_t     op;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mem_req_t;

    typedef struct packed {
        logic       ale;
        logic       program_fetch_strobe_n;
        logic       rd_n;
        logic       wr_n;
        logic [7:0] port_zero_addr_data;
        logic       port_zero_oe;
        logic [7:0] port_two_high_addr;
        logic       port_two_oe;
    } ext_bus_t;

endpackage : xmem_pkg

/* File: core/ale_divider.sv */
/*
 * Address latch strobe divider: one-cycle high pulse every ALE_DIVIDE
 * clocks. Assumes clk_sys is the oscillator clock.
 */
`timescale 1ns/1ns
`include "xmem_consts.svh"

module ale_divider #(
    parameter int DIVIDE = `ALE_DIVIDE
) (
    input  wire logic clk_sys,   // Oscillator clock
    input  wire logic rst_n,     // Async reset, active low
    output logic      ale        // Latch strobe, one clock wide
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       ale_d;

    always_comb begin
        cnt_d = (cnt_q == 4'(DIVIDE - 1)) ? 4'h0 : cnt_q + 4'h1;
        ale_d = (cnt_d == 4'h0);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            ale   <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ale   <= ale_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_ale_period: assert property (ale |=> !ale [*5] ##1 ale)
        else $error("latch strobe not at one sixth of oscillator");

endmodule : ale_divider

/* File: core/data_mem_access.sv */
/*
 * Data memory access and external bus logic: scratchpad, auxiliary RAM,
 * unlock-protected chip control, reset filter and multiplexed bus cycles.
 * Assumes a core that holds each request until done and inputs synchronous
 * to clk_sys.
 */
`timescale 1ns/1ns
`include "xmem_consts.svh"

// Overview of operation
// - High code select: internal fetch, bus quiet
// - Fetch strobe only for external fetches
// - Address latch strobe at oscillator over six
// - Reset input high two machine cycles resets
// - Port two carries high address externally
// - Lower scratchpad: direct and indirect
// - Upper scratchpad: indirect only
// - Enabled aux RAM serves low 1K moves
// - Moves above aux range go external
// - Chip control bit 4 enables aux RAM
// - Aux RAM access leaves bus pins idle
// - High page register supplies 8-bit pointer page
module data_mem_access
    import xmem_pkg::*;
#(
    parameter int AUX_DEPTH = 1024,
    parameter int RST_HOLD  = `OSC_PER_MACHINE_CYCLE * `RESET_MACHINE_CYCLES
) (
    input  wire logic       clk_sys,              // Oscillator clock, 25 MHz
    input  wire logic       rst_n,                // Power-on reset, async, active low
    input  wire logic       rst_pin,              // Reset pin, active high
    output logic            core_reset,           // Filtered reset to the core
    input  wire logic       external_code_select, // High: code from internal ROM
    input  mem_req_t        req,                  // Core memory request
    output logic            done,                 // Request completed, one clock
    output logic [7:0]      rdata,                // Read data, valid with done
    output logic [15:0]     rom_addr,             // Internal ROM address
    input  wire logic [7:0] rom_data,             // Internal ROM data
    input  wire logic       sfr_wr,               // SFR write strobe
    input  wire logic [7:0] sfr_addr,             // SFR address
    input  wire logic [7:0] sfr_wdata,            // SFR write data
    output logic [7:0]      sfr_rdata,            // SFR read data
    input  wire logic [7:0] port_zero_in,         // Port zero pin levels
    output ext_bus_t        bus                   // External bus pins
);
    typedef enum {S_IDLE, S_WAIT, S_ADDR, S_STRB, S_ACK} bus_state_t;

    // ****************************************
    // Reset filter
    // ****************************************
    logic [5:0] rst_cnt_q, rst_cnt_d;
    logic       core_reset_d;

    always_comb begin
        rst_cnt_d    = rst_pin ? rst_cnt_q : 6'h00;
        core_reset_d = 1'b0;
        if (rst_pin && rst_cnt_q < 6'(RST_HOLD))
            rst_cnt_d = rst_cnt_q + 6'h01;
        if (rst_pin && rst_cnt_q >= 6'(RST_HOLD - 1))
            core_reset_d = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_q  <= 6'h00;
            core_reset <= 1'b1;
        end else begin
            rst_cnt_q  <= rst_cnt_d;
            core_reset <= core_reset_d;
        end
    end

    // ****************************************
    // Special function registers
    // ****************************************
    logic [7:0] high_page_q, high_page_d;
    logic [7:0] chip_control_q, chip_control_d;
    logic [1:0] unlock_q, unlock_d;   // 0 locked, 1 first key seen, 2 open
    logic       aux_en;

    assign aux_en = chip_control_q[`CC_AUX_EN_BIT];

    always_comb begin
        high_page_d    = high_page_q;
        chip_control_d = chip_control_q;
        unlock_d       = unlock_q;
        if (core_reset) begin
            high_page_d    = `SFR_RESET_VALUE;
            chip_control_d = `SFR_RESET_VALUE;
            unlock_d       = 2'd0;
        end else if (sfr_wr) begin
            case (sfr_addr)
                `OFS_AUX_RAM_HIGH_PAGE: high_page_d = sfr_wdata;
                `OFS_CHIP_CONTROL: begin
                    if (unlock_q == 2'd2)
                        chip_control_d = sfr_wdata;
                end
                `OFS_CHIP_CONTROL_UNLOCK: begin
                    // Any value off the key sequence, 00 included, relocks
                    if (sfr_wdata == `UNLOCK_KEY_FIRST)
                        unlock_d = 2'd1;
                    else if (sfr_wdata == `UNLOCK_KEY_SECOND && unlock_q == 2'd1)
                        unlock_d = 2'd2;
                    else
                        unlock_d = 2'd0;
                end
                default: ;
            endcase
        end
    end

    always_comb begin
        case (sfr_addr)
            `OFS_AUX_RAM_HIGH_PAGE:   sfr_rdata = high_page_q;
            `OFS_CHIP_CONTROL:        sfr_rdata = chip_control_q;
            `OFS_CHIP_CONTROL_UNLOCK: sfr_rdata = {7'h00, unlock_q == 2'd2};
            default:                  sfr_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            high_page_q    <= `SFR_RESET_VALUE;
            chip_control_q <= `SFR_RESET_VALUE;
            unlock_q       <= 2'd0;
        end else begin
            high_page_q    <= high_page_d;
            chip_control_q <= chip_control_d;
            unlock_q       <= unlock_d;
        end
    end

    // ****************************************
    // Request decode
    // ****************************************
    function automatic logic [15:0] move_addr(mem_req_t r, logic [7:0] page);
        // 8-bit pointers take their page from the high page register
        move_addr = (r.op == OP_XPTR8) ? {page, r.addr[7:0]} : r.addr;
    endfunction

    function automatic logic is_move(mem_op_t op);
        is_move = (op == OP_XPTR8) || (op == OP_XDPTR);
    endfunction

    logic        ale;
    logic [15:0] xaddr;
    logic        aux_hit, take;
    bus_state_t  state_q, state_d;

    ale_divider #(.DIVIDE(`ALE_DIVIDE)) u_ale (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ale     (ale)
    );

    assign xaddr    = move_addr(req, high_page_q);
    assign aux_hit  = aux_en && is_move(req.op) && xaddr <= `AUX_RAM_TOP;
    assign take     = (state_q == S_IDLE) && req.valid && !core_reset;
    assign rom_addr = req.addr;

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] scratch [256];
    logic [7:0] aux_ram [AUX_DEPTH];
    logic       scr_we, aux_we, scr_ok;

    // Direct addresses above the lower half belong to SFR space, not this RAM
    assign scr_ok = (req.op == OP_INDIRECT) ||
                    (req.op == OP_DIRECT && req.addr[7:0] <= `SCRATCH_DIRECT_TOP);
    assign scr_we = take && req.wr && scr_ok;
    assign aux_we = take && req.wr && aux_hit;

    always_ff @(posedge clk_sys) begin
        if (scr_we)
            scratch[req.addr[7:0]] <= req.wdata;
        if (aux_we)
            aux_ram[xaddr[9:0]] <= req.wdata;
    end

    // ****************************************
    // Bus sequencer
    // ****************************************
    mem_op_t     op_q, op_d;
    logic        wr_q, wr_d;
    logic [15:0] addr_q, addr_d;
    logic [7:0]  wdata_q, wdata_d, rdata_d;
    logic        done_d;
    ext_bus_t    bus_d, bus_q;

    always_comb begin
        state_d = state_q;
        op_d    = op_q;
        wr_d    = wr_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata;
        done_d  = 1'b0;
        bus_d   = bus_q;
        bus_d.ale = ale;
        case (state_q)
            S_IDLE: begin
                if (take) begin
                    op_d    = req.op;
                    wr_d    = req.wr;
                    addr_d  = xaddr;
                    wdata_d = req.wdata;
                    if (req.op == OP_FETCH && external_code_select) begin
                        rdata_d = rom_data;
                        state_d = S_ACK;
                    end else if (req.op == OP_DIRECT || req.op == OP_INDIRECT) begin
                        rdata_d = scr_ok ? scratch[req.addr[7:0]] : 8'h00;
                        state_d = S_ACK;
                    end else if (aux_hit) begin
                        rdata_d = aux_ram[xaddr[9:0]];
                        state_d = S_ACK;
                    end else begin
                        state_d = S_WAIT;
                    end
                end
            end
            S_WAIT: begin
                // Align the address phase with the latch strobe
                if (ale) begin
                    bus_d.port_zero_addr_data = addr_q[7:0];
                    bus_d.port_zero_oe        = 1'b1;
                    bus_d.port_two_high_addr  = addr_q[15:8];
                    bus_d.port_two_oe         = 1'b1;
                    state_d = S_ADDR;
                end
            end
            S_ADDR: begin
                if (ale) begin
                    bus_d.port_zero_addr_data = wdata_q;
                    bus_d.port_zero_oe        = (op_q != OP_FETCH) && wr_q;
                    bus_d.program_fetch_strobe_n = (op_q != OP_FETCH);
                    bus_d.rd_n = !((op_q != OP_FETCH) && !wr_q);
                    bus_d.wr_n = !((op_q != OP_FETCH) && wr_q);
                    state_d = S_STRB;
                end
            end
            S_STRB: begin
                if (ale) begin
                    rdata_d = port_zero_in;
                    bus_d.program_fetch_strobe_n = 1'b1;
                    bus_d.rd_n         = 1'b1;
                    bus_d.wr_n         = 1'b1;
                    bus_d.port_zero_oe = 1'b0;
                    bus_d.port_two_oe  = 1'b0;
                    state_d = S_ACK;
                end
            end
            S_ACK: begin
                done_d  = 1'b0;
                state_d = S_IDLE;
            end
            default: state_d = S_IDLE;
        endcase
        if (state_d == S_ACK && state_q != S_ACK)
            done_d = 1'b1;
        if (core_reset) begin
            state_d = S_IDLE;
            bus_d.program_fetch_strobe_n = 1'b1;
            bus_d.rd_n         = 1'b1;
            bus_d.wr_n         = 1'b1;
            bus_d.port_zero_oe = 1'b0;
            bus_d.port_two_oe  = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= S_IDLE;
            op_q    <= OP_FETCH;
            wr_q    <= 1'b0;
            addr_q  <= 16'h0000;
            wdata_q <= 8'h00;
            rdata   <= 8'h00;
            done    <= 1'b0;
            bus_q   <= '{ale: 1'b0, program_fetch_strobe_n: 1'b1, rd_n: 1'b1,
                         wr_n: 1'b1, port_zero_addr_data: 8'h00, port_zero_oe: 1'b0,
                         port_two_high_addr: 8'h00, port_two_oe: 1'b0};
        end else begin
            state_q <= state_d;
            op_q    <= op_d;
            wr_q    <= wr_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata   <= rdata_d;
            done    <= done_d;
            bus_q   <= bus_d;
        end
    end

    assign bus = bus_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_int_fetch_quiet: assert property (take && req.op == OP_FETCH && external_code_select
        |=> state_q == S_ACK && bus_q.program_fetch_strobe_n && !bus_q.port_zero_oe)
        else $error("internal fetch touched the bus");
    a_fetch_strobe_only: assert property (!bus_q.program_fetch_strobe_n
        |-> op_q == OP_FETCH && bus_q.rd_n && bus_q.wr_n)
        else $error("fetch strobe outside external fetch");
    a_reset_hold: assert property ($rose(core_reset)
        |-> $past(rst_pin, 1) && $past(rst_pin, 23))
        else $error("reset taken before two machine cycles");
    a_high_addr_out: assert property (bus_q.port_two_oe
        |-> bus_q.port_two_high_addr == addr_q[15:8])
        else $error("port two not carrying high address");
    a_upper_direct: assert property (take && req.op == OP_DIRECT && req.addr[7]
        |=> rdata == 8'h00 && done)
        else $error("direct address reached upper scratchpad");
    a_aux_bus_idle: assert property (take && aux_hit
        |=> done && bus_q.rd_n && bus_q.wr_n && !bus_q.port_two_oe)
        else $error("aux RAM access disturbed bus pins");
    a_above_aux_ext: assert property (take && is_move(req.op) && !aux_hit
        |=> state_q == S_WAIT ##[1:6] state_q == S_ADDR)
        else $error("move above aux range not external");
    a_locked_write: assert property (sfr_wr && sfr_addr == `OFS_CHIP_CONTROL
        && unlock_q != 2'd2 |=> $stable(chip_control_q))
        else $error("locked chip control was written");

    c_ext_read:   cover property (state_q == S_STRB && !bus_q.rd_n ##[1:6] done);
    c_aux_write:  cover property (aux_we);
    c_unlocked:   cover property (unlock_q == 2'd2 && sfr_wr && sfr_addr == `OFS_CHIP_CONTROL);

endmodule : data_mem_access

/* File: bench/ext_mem_model.sv */
/*
 * Behavioural external program ROM and data SRAM on the multiplexed bus,
 * with its own address latch. Assumes the bus pins of data_mem_access
 * and a testbench that reads pat() for untouched locations.
 */
`timescale 1ns/1ns

module ext_mem_model
    import xmem_pkg::*;
(
    input  wire logic  clk_sys,      // Oscillator clock
    input  ext_bus_t   bus,          // Bus pins from the device
    output logic [7:0] port_zero_in  // Port zero as the device sees it
);
    logic [15:0] addr_q;
    logic [7:0]  store [logic [15:0]];

    // Contents of locations never written: low address byte XOR high byte XOR 5A
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : pat

    initial port_zero_in = 8'h00;

    always @(posedge clk_sys) begin
        if (bus.ale && bus.port_zero_oe && bus.port_two_oe && bus.rd_n && bus.wr_n
            && bus.program_fetch_strobe_n) begin
            addr_q <= {bus.port_two_high_addr, bus.port_zero_addr_data};
        end
        if (!bus.wr_n && bus.port_zero_oe) begin
            store[addr_q] = bus.port_zero_addr_data;
        end
        if (!bus.rd_n || !bus.program_fetch_strobe_n) begin
            port_zero_in <= store.exists(addr_q) ? store[addr_q] : pat(addr_q);
        end else begin
            // Open drain and released: never leave the last byte standing
            port_zero_in <= ~port_zero_in;
        end
    end
endmodule : ext_mem_model

/* File: bench/data_mem_access_tb_top.sv */
/*
 * Self-checking testbench of data_mem_access with an external memory model.
 * Assumes the assertions live in the design files.
 */
`timescale 1ns/1ns
`include "xmem_consts.svh"

module data_mem_access_tb_top
    import xmem_pkg::*;
;
    localparam int        HOLD = 24;
    localparam logic [7:0] PG  = `OFS_AUX_RAM_HIGH_PAGE;
    localparam logic [7:0] CC  = `OFS_CHIP_CONTROL;
    localparam logic [7:0] UL  = `OFS_CHIP_CONTROL_UNLOCK;

    logic        clk_sys   = 1'b0;
    logic        rst_n     = 1'b0;
    logic        rst_pin   = 1'b0;
    logic        ext_sel   = 1'b1;
    mem_req_t    req       = '0;
    logic [7:0]  rom_data  = 8'h00;
    logic        sfr_wr    = 1'b0;
    logic [7:0]  sfr_addr  = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [7:0]  port_zero_in;
    logic        core_reset;
    logic        done;
    logic [7:0]  rdata;
    logic [7:0]  sfr_rdata;
    logic [15:0] rom_addr;
    ext_bus_t    bus;
    logic [8:0]  exp_q [$];
    logic [8:0]  e;
    logic [7:0]  d;
    logic [7:0]  d2;
    int          miscompares = 0;
    int          num_checks  = 0;
    int          seed        = 32'h874e_b3e2;
    int          pins_busy   = 0;
    int          fetch_lo    = 0;
    int          n;
    int          k;
    int          b0;

    always #20 clk_sys = ~clk_sys;

    data_mem_access #(.RST_HOLD(HOLD)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .rst_pin(rst_pin), .core_reset(core_reset),
        .external_code_select(ext_sel), .req(req), .done(done), .rdata(rdata),
        .rom_addr(rom_addr), .rom_data(rom_data), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .port_zero_in(port_zero_in),
        .bus(bus));

    ext_mem_model mem_m (.clk_sys(clk_sys), .bus(bus), .port_zero_in(port_zero_in));

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // ****************************************
    // Drivers
    // ****************************************
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        sfr_wr    <= 1'b1;
        sfr_addr  <= a;
        sfr_wdata <= v;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask : sfr_w

    task automatic sfr_chk(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        sfr_addr <= a;
        @(posedge clk_sys);
        #1;
        chk8(sfr_rdata, v);
    endtask : sfr_chk

    // Request stands until the edge that samples done high; the design sits
    // in its acknowledge state there, so it is never taken twice
    task automatic mem(input mem_op_t op, input logic wr, input logic [15:0] a,
                       input logic [7:0] wd, input logic [8:0] ex);
        @(posedge clk_sys);
        req <= '{valid: 1'b1, op: op, wr: wr, addr: a, wdata: wd};
        exp_q.push_back(ex);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (done !== 1'b1 && n < 40);
        req.valid <= 1'b0;
        if (n >= 40) begin
            miscompares++;
            final_report();
        end
    endtask : mem

    // ****************************************
    // Monitor
    // ****************************************
    always @(posedge clk_sys) begin
        if (bus.rd_n !== 1'b1 || bus.wr_n !== 1'b1 || bus.port_zero_oe !== 1'b0
            || bus.port_two_oe !== 1'b0 || bus.program_fetch_strobe_n !== 1'b1) pins_busy++;
        if (bus.program_fetch_strobe_n === 1'b0) fetch_lo++;
        if (done === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e[8]) chk8(rdata, e[7:0]);
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk8({7'h00, core_reset}, 8'h00);
        sfr_chk(PG, 8'h00);
        sfr_chk(CC, 8'h00);
        sfr_chk(UL, 8'h00);
        sfr_w(CC, 8'h10);
        sfr_chk(CC, 8'h00);
        sfr_w(UL, `UNLOCK_KEY_FIRST);
        sfr_w(UL, 8'h12);
        sfr_w(CC, 8'h10);
        sfr_chk(CC, 8'h00);
        sfr_w(UL, `UNLOCK_KEY_FIRST);
        sfr_w(UL, `UNLOCK_KEY_SECOND);
        sfr_chk(UL, 8'h01);
        sfr_w(CC, 8'h10);
        sfr_w(UL, 8'h00);
        sfr_chk(UL, 8'h00);
        sfr_w(CC, 8'h00);
        sfr_chk(CC, 8'h10);
        $display("test unlock done");
        // Scratchpad: upper half must refuse direct access
        d = 8'($random(seed));
        d2 = 8'($random(seed));
        mem(OP_DIRECT, 1'b1, 16'h007F, d, 9'h000);
        mem(OP_INDIRECT, 1'b0, 16'h007F, 8'h00, {1'b1, d});
        chk8(8'(n), 8'd2);
        mem(OP_INDIRECT, 1'b1, 16'h00FF, d2, 9'h000);
        mem(OP_DIRECT, 1'b1, 16'h00FF, ~d2, 9'h000);
        mem(OP_DIRECT, 1'b0, 16'h0080, 8'h00, 9'h100);
        mem(OP_INDIRECT, 1'b0, 16'h00FF, 8'h00, {1'b1, d2});
        $display("test scratchpad done");
        b0 = pins_busy;
        sfr_w(PG, 8'h01);
        mem(OP_XPTR8, 1'b1, 16'h0023, d, 9'h000);
        mem(OP_XDPTR, 1'b0, 16'h0123, 8'h00, {1'b1, d});
        chk8(8'(n), 8'd2);
        sfr_w(PG, 8'h03);
        mem(OP_XPTR8, 1'b1, 16'h00FF, d2, 9'h000);
        mem(OP_XDPTR, 1'b0, 16'h03FF, 8'h00, {1'b1, d2});
        chk8(8'(pins_busy - b0), 8'h00);
        $display("test aux ram done");
        mem(OP_XDPTR, 1'b0, 16'h0400, 8'h00, {1'b1, mem_m.pat(16'h0400)});
        chk8({7'h00, n >= 15 && n <= 20}, 8'h01);
        mem(OP_XDPTR, 1'b1, 16'h7FFF, d, 9'h000);
        mem(OP_XDPTR, 1'b0, 16'h7FFF, 8'h00, {1'b1, d});
        sfr_w(PG, 8'h12);
        mem(OP_XPTR8, 1'b0, 16'h0034, 8'h00, {1'b1, mem_m.pat(16'h1234)});
        $display("test external done");
        b0 = pins_busy;
        k = fetch_lo;
        d = 8'($random(seed));
        @(posedge clk_sys);
        rom_data <= d;
        mem(OP_FETCH, 1'b0, 16'h1234, 8'h00, {1'b1, d});
        chk8(rom_addr[7:0], 8'h34);
        chk8(rom_addr[15:8], 8'h12);
        chk8(8'(pins_busy - b0), 8'h00);
        chk8(8'(fetch_lo - k), 8'h00);
        ext_sel <= 1'b0;
        mem(OP_FETCH, 1'b0, 16'h0456, 8'h00, {1'b1, mem_m.pat(16'h0456)});
        chk8({7'h00, fetch_lo > k}, 8'h01);
        ext_sel <= 1'b1;
        k = 0;
        repeat (60) begin
            @(posedge clk_sys);
            if (bus.ale === 1'b1) k++;
        end
        chk8(8'(k), 8'd10);
        $display("test fetch and latch done");
        // Reset pin must be held the full count before the core resets
        @(posedge clk_sys);
        rst_pin <= 1'b1;
        for (int i = 1; i <= HOLD; i++) begin
            @(posedge clk_sys);
            #1;
            if (i == HOLD - 1) chk8({7'h00, core_reset}, 8'h00);
        end
        chk8({7'h00, core_reset}, 8'h01);
        @(posedge clk_sys);
        rst_pin <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk8({7'h00, core_reset}, 8'h00);
        sfr_chk(CC, 8'h00);
        mem(OP_XDPTR, 1'b0, 16'h0123, 8'h00, {1'b1, mem_m.pat(16'h0123)});
        repeat (2) @(posedge clk_sys);
        chk8(8'(exp_q.size()), 8'h00);
        $display("test reset pin done");
        final_report();
    end
endmodule : data_mem_access_tb_top
